// >>> src/wstp_pkg.sv
// Purpose: shared constants and types for the sample playback path
// Assumes: one sample clock, 18-bit raw sample words
// Notes: marker bits sit in the two lowest bits of each word
package wstp_pkg;
  localparam int SAMPLE_W = 18;
  localparam int ANALOG_W = 16;
  localparam int MARKER_W = 2;
  localparam int MARKER_LSB = 0;
  localparam int ANALOG_LSB = 2;
  localparam int GRAN = 16;
  localparam int GRAN_W = 4;
  localparam int LEN_W = 16;
  localparam int NUM_TRIG = 2;
  localparam int SRC_N = 4;
  localparam int SRC_SEL_W = 2;
  localparam int FIFO_DEPTH = 8;
  localparam logic [ANALOG_W-1:0] ANALOG_NEG_FS = 16'h0000;
  localparam logic [ANALOG_W-1:0] ANALOG_POS_FS = 16'hffff;
  localparam logic [ANALOG_W-1:0] ANALOG_MID = 16'h8000;
  localparam logic [MARKER_W-1:0] MARKER_NONE = 2'h0;
  localparam logic [SAMPLE_W-1:0] SAMPLE_ZERO = 18'h00000;

  // Raw sample word: analog above, markers below
  typedef struct packed {
    logic [ANALOG_W-1:0] analog;
    logic [MARKER_W-1:0] marker;
  } wstp_sample_s;

  // Signed normalised amplitude and markers as offered by the sequencer
  typedef struct packed {
    logic signed [ANALOG_W-1:0] amp_a;
    logic signed [ANALOG_W-1:0] amp_b;
    logic [MARKER_W-1:0] mark_a;
    logic [MARKER_W-1:0] mark_b;
    logic sum_en;
  } wstp_src_s;

  // Sequencer command
  typedef struct packed {
    logic is_wait;
    logic trig_ch;
    logic [LEN_W-1:0] length;
  } wstp_cmd_s;

  typedef struct packed {
    logic [SRC_SEL_W-1:0] sel;
    logic rise_en;
    logic fall_en;
  } wstp_trig_cfg_s;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_WAIT = 4'h2,
    ST_PLAY = 4'h4,
    ST_PAD = 4'h8
  } wstp_state_e;
endpackage

// >>> src/wstp_fifo.sv
// Purpose: small flip-flop FIFO with valid/ready on both sides
// Assumes: single clock, synchronous active-low reset
// Notes: depth must be a power of two
`timescale 1ns/1ps
module wstp_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
  end

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0] cnt_ff;
  logic push;
  logic pop;

  // Honest flags from the occupancy count
  assign in_ready = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_ff[rd_ff];

  // Storage
  always_ff @(posedge sys_clk) begin
    if (clk_en && push) begin
      mem_ff[wr_ff] <= in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else if (clk_en) begin
      if (push) wr_ff <= wr_ff + 1'b1;
      if (pop) rd_ff <= rd_ff + 1'b1;
      if (push && !pop) cnt_ff <= cnt_ff + 1'b1;
      else if (pop && !push) cnt_ff <= cnt_ff - 1'b1;
    end
  end
endmodule // wstp_fifo

// >>> src/wstp_playback.sv
// Purpose: sample formatting and trigger-gated waveform playback
// Assumes: one sample clock, sequencer on same clock, trigger pins async
// Notes: samples pass an 8-word FIFO before the output stage
`timescale 1ns/1ps
module wstp_playback
  import wstp_pkg::*;
#(
  parameter int NUM_SRC = wstp_pkg::SRC_N,
  parameter int DEPTH = wstp_pkg::FIFO_DEPTH
) (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Sequencer command port
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire wstp_pkg::wstp_cmd_s cmd,
  // Sample source
  input wire logic src_valid,
  output logic src_ready,
  input wire wstp_pkg::wstp_src_s src,
  // Trigger configuration and sources
  input wire wstp_pkg::wstp_trig_cfg_s trig_cfg [wstp_pkg::NUM_TRIG],
  input wire logic [NUM_SRC-1:0] trig_src_pins,
  // Output stage
  output logic out_valid,
  input wire logic out_ready,
  output wstp_pkg::wstp_sample_s out_sample,
  output logic [wstp_pkg::MARKER_W-1:0] marker_out,
  // Status
  output logic busy,
  output logic [wstp_pkg::NUM_TRIG-1:0] trig_edge_seen
);
  import wstp_pkg::*;

  initial begin
    if (NUM_SRC < 1 || NUM_SRC > (1 << SRC_SEL_W)) $error("NUM_SRC out of range");
    if (DEPTH < 2) $error("DEPTH too small");
  end

  // Two-stage synchronisers for the asynchronous trigger sources
  logic [NUM_SRC-1:0] sync1_ff;
  logic [NUM_SRC-1:0] sync2_ff;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else if (clk_en) begin
      sync1_ff <= trig_src_pins;
      sync2_ff <= sync1_ff;
    end
  end

  // Per-channel selector and edge detector
  logic [NUM_TRIG-1:0] sel_lvl;
  logic [NUM_TRIG-1:0] prev_ff;
  logic [NUM_TRIG-1:0] edge_hit;
  logic [NUM_TRIG-1:0] sel_ok;
  always_comb begin
    for (int c = 0; c < NUM_TRIG; c++) begin
      sel_ok[c] = (int'(trig_cfg[c].sel) < NUM_SRC);
      sel_lvl[c] = sel_ok[c] ? sync2_ff[trig_cfg[c].sel] : 1'b0;
      edge_hit[c] = (trig_cfg[c].rise_en && sel_lvl[c] && !prev_ff[c]) ||
                    (trig_cfg[c].fall_en && !sel_lvl[c] && prev_ff[c]);
    end
  end

  // Previous level; a source change compares the new source's level against the old source's level
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      prev_ff <= '0;
    end else if (clk_en) begin
      prev_ff <= sel_lvl;
    end
  end

  // Sticky edge indication per channel; the edge that ends a wait sets it, so only reset clears it
  logic wait_done;
  logic wait_ch_ff;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      trig_edge_seen <= '0;
    end else if (clk_en) begin
      for (int c = 0; c < NUM_TRIG; c++) begin
        if (edge_hit[c]) trig_edge_seen[c] <= 1'b1;
        else if (wait_done && (int'(wait_ch_ff) == c)) trig_edge_seen[c] <= 1'b0;
      end
    end
  end

  // Sequencer state
  wstp_state_e state_ff;
  logic [LEN_W-1:0] remain_ff;
  logic [GRAN_W-1:0] phase_ff;
  logic fifo_in_ready;
  logic fifo_in_valid;
  wstp_sample_s fifo_in_data;
  logic take_src;
  logic take_pad;

  assign cmd_ready = (state_ff == ST_IDLE);
  assign busy = (state_ff != ST_IDLE);
  assign wait_done = (state_ff == ST_WAIT) && edge_hit[wait_ch_ff];
  assign take_src = (state_ff == ST_PLAY) && src_valid && fifo_in_ready;
  assign take_pad = (state_ff == ST_PAD) && fifo_in_ready;
  assign src_ready = (state_ff == ST_PLAY) && fifo_in_ready;

  // Command flow; a wait blocks the next play so starts follow the trigger
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      wait_ch_ff <= 1'b0;
      remain_ff <= '0;
      phase_ff <= '0;
    end else if (clk_en) begin
      unique case (state_ff)
        ST_IDLE: begin
          if (cmd_valid) begin
            if (cmd.is_wait) begin
              state_ff <= ST_WAIT;
              wait_ch_ff <= cmd.trig_ch;
            end else if (cmd.length != '0) begin
              state_ff <= ST_PLAY;
              remain_ff <= cmd.length;
              phase_ff <= '0;
            end
          end
        end
        ST_WAIT: begin
          if (wait_done) state_ff <= ST_IDLE;
        end
        ST_PLAY: begin
          if (take_src) begin
            remain_ff <= remain_ff - 1'b1;
            phase_ff <= phase_ff + 1'b1;
            if (remain_ff == LEN_W'(1)) begin
              // Pad out the last group of sixteen
              if (phase_ff == GRAN_W'(GRAN-1)) state_ff <= ST_IDLE;
              else state_ff <= ST_PAD;
            end
          end
        end
        ST_PAD: begin
          if (take_pad) begin
            phase_ff <= phase_ff + 1'b1;
            if (phase_ff == GRAN_W'(GRAN-1)) state_ff <= ST_IDLE;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // Amplitude sum, saturated to the signed range of minus one to plus one
  logic signed [ANALOG_W:0] amp_sum;
  logic signed [ANALOG_W-1:0] amp_sat;
  logic [ANALOG_W-1:0] amp_code;
  logic [MARKER_W-1:0] mark_comb;
  always_comb begin
    amp_sum = src.sum_en ? (ANALOG_W+1)'(src.amp_a) + (ANALOG_W+1)'(src.amp_b)
                         : (ANALOG_W+1)'(src.amp_a);
    // Clip keeps a summed overshoot at full scale instead of wrapping
    if (amp_sum > (ANALOG_W+1)'(signed'({1'b0, ~ANALOG_MID}))) begin
      amp_sat = signed'(~ANALOG_MID);
    end else if (amp_sum < -(ANALOG_W+1)'(signed'({1'b0, ANALOG_MID}))) begin
      amp_sat = signed'(ANALOG_MID);
    end else begin
      amp_sat = amp_sum[ANALOG_W-1:0];
    end
    // Offset binary: most negative gives code zero, most positive all ones
    amp_code = amp_sat ^ ANALOG_MID;
    mark_comb = src.sum_en ? (src.mark_a | src.mark_b) : src.mark_a;
  end

  // Pack the raw word; pad samples are all zero
  always_comb begin
    fifo_in_valid = take_src || take_pad;
    if (take_pad) begin
      fifo_in_data = wstp_sample_s'(SAMPLE_ZERO);
    end else begin
      fifo_in_data.analog = amp_code;
      fifo_in_data.marker = mark_comb;
    end
  end

  // Buffer between sequencer and output stage; a full FIFO stalls playback
  wstp_fifo #(
    .WIDTH(SAMPLE_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(out_valid),
    .out_ready(out_ready && clk_en),
    .out_data(out_sample)
  );

  // Marker pins held from the last sample taken by the output stage
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      marker_out <= MARKER_NONE;
    end else if (clk_en && out_valid && out_ready) begin
      marker_out <= out_sample.marker;
    end
  end
endmodule // wstp_playback

// >>> bench/wstp_far_model.sv
// Purpose: far side model, trigger pins and output stage
// Assumes: bench asks for a pin pulse with a one-cycle request
// Notes: stall mode takes a word only every other cycle
`timescale 1ns/1ps
module wstp_far_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Requests from the bench
  input wire logic stall,
  input wire logic [3:0] pulse,
  // Towards the block
  output logic [3:0] trig_src_pins,
  output logic out_ready
);
  logic [2:0] hold_ff [4];
  // Pulse held six cycles so the two-flop sync cannot miss it
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < 4; i++) begin
      if (!rst_n) hold_ff[i] <= 3'h0;
      else if (pulse[i]) hold_ff[i] <= 3'h6;
      else if (hold_ff[i] != 3'h0) hold_ff[i] <= hold_ff[i] - 3'h1;
    end
  end
  // Pins fall back low once the hold runs out
  always_comb begin
    for (int i = 0; i < 4; i++) trig_src_pins[i] = (hold_ff[i] != 3'h0);
  end
  // Slow stage toggles ready so the FIFO fills up
  always_ff @(posedge sys_clk) begin
    if (!rst_n) out_ready <= 1'b1;
    else out_ready <= !stall || !out_ready;
  end
endmodule // wstp_far_model

// >>> bench/wstp_playback_checker.sv
// Purpose: port-level checks on the playback block
// Assumes: trigger config held steady while edges arrive
// Notes: attached by bind after the module
`timescale 1ns/1ps
module wstp_playback_checker #(
  parameter int NUM_SRC = 4
) (
  // Clock and control
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Command and samples
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire wstp_pkg::wstp_cmd_s cmd,
  input wire logic src_valid,
  input wire logic src_ready,
  // Triggers
  input wire wstp_pkg::wstp_trig_cfg_s trig_cfg [wstp_pkg::NUM_TRIG],
  input wire logic [NUM_SRC-1:0] trig_src_pins,
  // Output and status
  input wire logic out_valid,
  input wire logic out_ready,
  input wire wstp_pkg::wstp_sample_s out_sample,
  input wire logic [wstp_pkg::MARKER_W-1:0] marker_out,
  input wire logic busy,
  input wire logic [wstp_pkg::NUM_TRIG-1:0] trig_edge_seen
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_ready_idle: assert property (cmd_ready == !busy)
    else $error("cmd_ready does not mirror idle");
  a_cmd_busy: assert property (clk_en && cmd_valid && cmd_ready
    && (cmd.is_wait || cmd.length != 16'h0) |=> busy) else $error("command not started");
  a_src_busy: assert property (src_ready |-> busy)
    else $error("sample taken while idle");
  a_src_push: assert property (clk_en && src_valid && src_ready |=> out_valid)
    else $error("taken sample not offered");
  a_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_sample))
    else $error("output word changed while stalled");
  a_marker_pop: assert property (clk_en && out_valid && out_ready
    |=> marker_out == $past(out_sample.marker)) else $error("marker not from popped word");
  a_freeze_hold: assert property (!clk_en |=> $stable(busy) && $stable(marker_out))
    else $error("state moved with clock enable low");
  a_edge_flag: assert property (clk_en && trig_cfg[0].rise_en
    && $rose(trig_src_pins[trig_cfg[0].sel]) |-> ##[2:4] trig_edge_seen[0])
    else $error("rising edge not flagged");
  a_fall_flag: assert property (clk_en && trig_cfg[1].fall_en
    && $fell(trig_src_pins[trig_cfg[1].sel]) |-> ##[2:4] trig_edge_seen[1])
    else $error("falling edge not flagged");
endmodule // wstp_playback_checker

bind wstp_playback wstp_playback_checker #(.NUM_SRC(NUM_SRC)) i_chk (.sys_clk(sys_clk),
  .rst_n(rst_n), .clk_en(clk_en), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
  .src_valid(src_valid), .src_ready(src_ready), .trig_cfg(trig_cfg),
  .trig_src_pins(trig_src_pins), .out_valid(out_valid), .out_ready(out_ready),
  .out_sample(out_sample), .marker_out(marker_out), .busy(busy),
  .trig_edge_seen(trig_edge_seen));

// >>> bench/waveform_sample_trigger_playback_tb_top.sv
// Purpose: self-checking bench for the playback block
// Assumes: inputs change on the falling edge
// Notes: pad words expected as all-zero words
`timescale 1ns/1ps
module waveform_sample_trigger_playback_tb_top;
  import wstp_pkg::*;
  typedef struct {int len; logic [15:0] a, b; logic [1:0] ma, mb; logic sm, stl;
    logic [17:0] exp;} wstp_row_s;
  wstp_row_s rows [5] = '{'{1, 16'h8000, 16'h0, 2'h1, 2'h0, 0, 0, 18'h00001},
    '{16, 16'h7fff, 16'h0, 2'h2, 2'h0, 0, 0, 18'h3fffe},
    '{17, 16'h0000, 16'h0, 2'h3, 2'h0, 0, 1, 18'h20003},
    '{1, 16'h7000, 16'h7000, 2'h1, 2'h2, 1, 0, 18'h3ffff},
    '{2, 16'h8000, 16'hffff, 2'h0, 2'h2, 1, 0, 18'h00002}};
  logic sys_clk = 0, rst_n = 0, clk_en = 1, cmd_valid = 0, src_valid = 0, stall = 0;
  logic cmd_ready, src_ready, out_valid, out_ready, busy;
  logic [3:0] pulse = 4'h0, trig_src_pins;
  logic [1:0] marker_out, trig_edge_seen;
  wstp_cmd_s cmd = '0;
  wstp_src_s src = '0;
  wstp_trig_cfg_s trig_cfg [NUM_TRIG];
  wstp_sample_s out_sample;
  wstp_sample_s got [$];
  int err_total = 0, n_compared = 0, cyc = 0, take_cyc, pc0, st0;
  wstp_playback i_wstp_playback (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .src_valid(src_valid),
    .src_ready(src_ready), .src(src), .trig_cfg(trig_cfg), .trig_src_pins(trig_src_pins),
    .out_valid(out_valid), .out_ready(out_ready), .out_sample(out_sample),
    .marker_out(marker_out), .busy(busy), .trig_edge_seen(trig_edge_seen));
  wstp_far_model i_wstp_far_model (.sys_clk(sys_clk), .rst_n(rst_n), .stall(stall),
    .pulse(pulse), .trig_src_pins(trig_src_pins), .out_ready(out_ready));
  always #2 sys_clk = ~sys_clk;
  // Pre-edge values: takes and pops as the design saw them
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (rst_n && clk_en && src_valid && src_ready) take_cyc = cyc;
    if (rst_n && clk_en && out_valid && out_ready) got.push_back(out_sample);
  end
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(string what, logic [17:0] exp, logic [17:0] seen);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Bounded wait for the block to go idle
  task automatic wait_idle();
    int n = 0;
    while (busy !== 1'b0 && n < 2000) begin
      @(negedge sys_clk);
      n++;
    end
    if (busy !== 1'b0) begin
      err_total++;
      close_out();
    end
  endtask
  task automatic issue(logic w, logic ch, logic [15:0] len);
    @(negedge sys_clk);
    cmd_valid = 1;
    cmd = '{w, ch, len};
    @(negedge sys_clk);
    cmd_valid = 0;
  endtask
  task automatic pulse_pins(logic [3:0] p);
    pulse = p;
    @(negedge sys_clk);
    pulse = 4'h0;
  endtask
  task automatic run_row(wstp_row_s r);
    got.delete();
    stall = r.stl;
    src = '{r.a, r.b, r.ma, r.mb, r.sm};
    src_valid = 1;
    issue(0, 0, r.len[15:0]);
    if (r.stl) begin
      clk_en = 0;
      repeat (3) @(negedge sys_clk);
      clk_en = 1;
    end
    wait_idle();
    src_valid = 0;
    repeat (20) @(negedge sys_clk);
    chk("word count", (r.len + 15) / 16 * 16, got.size());
    for (int i = 0; i < got.size(); i++)
      chk("word", i < r.len ? r.exp : SAMPLE_ZERO, got[i]);
    chk("marker out", r.len % 16 ? 2'h0 : r.exp[1:0], marker_out);
  endtask
  initial begin
    trig_cfg[0] = '{2'h0, 1'b1, 1'b0};
    trig_cfg[1] = '{2'h2, 1'b0, 1'b1};
    repeat (4) @(negedge sys_clk);
    rst_n = 1;
    chk("reset state", 18'h10, {cmd_ready, out_valid, busy, marker_out});
    foreach (rows[k]) run_row(rows[k]);
    // Wait then play twice; starts must follow the pin, not the wave
    pc0 = -100;
    for (int k = 0; k < 2; k++) begin
      issue(1, 0, 16'h0);
      while (cyc < pc0 + 100) @(negedge sys_clk);
      chk("stalled", 1, busy);
      pc0 = cyc;
      pulse_pins(4'h1);
      wait_idle();
      chk("edge flag", 1, trig_edge_seen[0]);
      src_valid = 1;
      issue(0, 0, 16'h1);
      wait_idle();
      src_valid = 0;
      if (k == 0) st0 = take_cyc;
    end
    chk("start spacing", 100, take_cyc - st0);
    // Channel 1 watches pin 2 for a fall only
    issue(1, 1, 16'h0);
    pulse_pins(4'h2);
    pulse_pins(4'h4);
    repeat (4) @(negedge sys_clk);
    chk("fall wait", 1, busy);
    wait_idle();
    chk("edge flag ch1", 1, trig_edge_seen[1]);
    close_out();
  end
endmodule // waveform_sample_trigger_playback_tb_top
